// File: rtl/gca_accum_cell.sv
// one 32-bit accumulator or elapsed time counter
`timescale 1ns/100ps
`include "gca_params.svh"
module gca_accum_cell (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // update request
    input wire logic i_add_en,
    input wire logic [31:0] i_addend,
    // running value
    output logic [31:0] o_value
);
    // plain modulo add, no saturation on purpose (see [RULE21])
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_value <= `GCA_CNT_RESET;
        end else if (i_add_en) begin
            o_value <= o_value + i_addend;
        end
    end
endmodule

// File: rtl/gca_dummy_placeholder_removed.sv
// no logic lives here; the block's modules sit in the other rtl files

// File: rtl/gca_half_sec_tick.sv
// half-second enable pulse divider
`timescale 1ns/100ps
`include "gca_params.svh"
module gca_half_sec_tick #(
    parameter int unsigned CYCLES = 50000000
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // one-cycle pulse every CYCLES clocks
    output logic o_tick
);
    logic [31:0] count_q;

    // free-running divider, wraps after the last count
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            count_q <= `GCA_CNT_RESET;
            o_tick <= 1'b0;
        end else if (count_q == CYCLES[31:0] - 32'h0000_0001) begin
            count_q <= `GCA_CNT_RESET;
            o_tick <= 1'b1;
        end else begin
            count_q <= count_q + 32'h0000_0001;
            o_tick <= 1'b0;
        end
    end
endmodule

// File: rtl/gca_params.svh
// gauge channel accumulation constants: map, fields, codes and timing
`ifndef GCA_PARAMS_SVH
`define GCA_PARAMS_SVH

// clock and timing figures
`define GCA_CLK_PERIOD_NS 10.0
`define GCA_T_ADC_UNIT_US 30.52
`define GCA_HALF_SEC_S 0.5
`define GCA_MIN_BITS 4'h8

// control register fields
`define GCA_CTL_EN 7
`define GCA_CTL_RES_HI 6
`define GCA_CTL_RES_LO 4
`define GCA_CTL_REF 3
`define GCA_CTL_SEL_HI 2
`define GCA_CTL_SEL_LO 0
`define GCA_CTL_RESET 8'h00

// converter input select codes
`define GCA_SEL_SENSE 3'h0
`define GCA_SEL_INT_TEMP 3'h1
`define GCA_SEL_EXT_TEMP 3'h2
`define GCA_SEL_PACK 3'h3
`define GCA_SEL_AUX 3'h5
`define GCA_SEL_ZERO_CAL 3'h6

// conversion slots, one per control register
`define GCA_SLOT_CURRENT 3'h0
`define GCA_SLOT_INT_TEMP 3'h1
`define GCA_SLOT_EXT_TEMP 3'h2
`define GCA_SLOT_RESERVED 3'h4
`define GCA_SLOT_AUX 3'h5
`define GCA_SLOT_ZERO_CAL 3'h6

// result word layout
`define GCA_RES_SIGN 15
`define GCA_MAG_FULL 15'h7fff
`define GCA_MAG_HI 14
`define GCA_RES_RESET 16'h0000

// sum_control_reg fields
`define GCA_SUM_ACCUM 0
`define GCA_SUM_THERM_EN 1
`define GCA_SUM_AUX_EN 2
`define GCA_SUM_THERM_EXT 3
`define GCA_SUM_TIMER_EN 4
`define GCA_SUM_RESET 8'h00

// counter indices
`define GCA_CNT_DRAIN 0
`define GCA_CNT_CHARGE 1
`define GCA_CNT_THERMAL 2
`define GCA_CNT_AUX 3
`define GCA_CNT_DIS_TIMER 4
`define GCA_CNT_CHG_TIMER 5
`define GCA_CNT_THERM_TIMER 6
`define GCA_CNT_AUX_TIMER 7
`define GCA_TIMER_STEP 32'h0000_0001
`define GCA_CNT_RESET 32'h0000_0000

// register byte map
`define GCA_ADDR_CTRL_BASE 8'h00
`define GCA_ADDR_CTRL_LAST 8'h07
`define GCA_ADDR_RES_BASE 8'h08
`define GCA_ADDR_RES_LAST 8'h17
`define GCA_ADDR_CNT_BASE 8'h20
`define GCA_ADDR_CNT_LAST 8'h3f
`define GCA_ADDR_SUM_CTL 8'h40
`define GCA_ADDR_STATUS 8'h41
`define GCA_READ_ZERO 8'h00

`endif

// File: rtl/gca_pkg.sv
// gauge channel accumulation types
package gca_pkg;
    // conversion sequencer states
    typedef enum logic [0:0] {
        GCA_ST_SCAN,
        GCA_ST_CONV
    } gca_seq_state_type;
endpackage

// File: rtl/gca_top.sv
// gauge channel setup, conversion sequencing and accumulation
//
// Summary of operation
// [RULE1] current control: enable b7, resolution b6-4, reference b3, input b2-0
// [RULE2] host sets pack voltage control to input 011, code 010, 340mV
// [RULE3] host points pack voltage and aux selects at their intended inputs
// [RULE4] charge/drain sums and timers use only the current result
// [RULE5] host picks 340mV reference for internal temperature conversion
// [RULE6] thermistor current source on only during external temp conversion
// [RULE7] zero-cal slot shorts input to ground, stores in zero-cal result
// [RULE8] four 32-bit accumulators and four 32-bit elapsed time counters
// [RULE9] thermal takes internal or external temp; aux takes aux result
// [RULE10] enabled accumulators add their source result every half second
// [RULE11] sign 0 means charging: magnitude added to charge accumulator
// [RULE12] sign 1 means discharge: magnitude added to drain accumulator
// [RULE13] accumulated resolution follows conversion resolution, max 15 bits
// [RULE14] charge and drain accumulators update only with sum-enable set
// [RULE15] charging timer gains 2 counts per second while charging
// [RULE16] discharge timer gains 2 counts per second while discharging
// [RULE17] results are sign-magnitude, sign b15, low bits zero-filled
// [RULE18] sequencer walks eight control slots, skipping disabled ones
// [RULE19] 3-bit resolution code selects 8 to 15 magnitude bits
// [RULE20] conversion lasts 30.52us times two to the power N plus one
// [RULE21] accumulators and timers wrap modulo two to the 32
`timescale 1ns/100ps
`include "gca_params.svh"
module gca_top #(
    parameter int unsigned CONV_UNIT_CYCLES =
        int'(`GCA_T_ADC_UNIT_US * 1000.0 / `GCA_CLK_PERIOD_NS),
    parameter int unsigned HALF_SEC_CYCLES =
        int'(`GCA_HALF_SEC_S * 1.0e9 / `GCA_CLK_PERIOD_NS)
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // byte register port from the serial bus decoder
    input wire logic i_reg_wr_en,
    input wire logic i_reg_rd_en,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rd_valid,
    // analog converter and input multiplexer
    input wire logic [15:0] i_adc_result,
    output logic o_adc_active,
    output logic [2:0] o_adc_input_sel,
    output logic [2:0] o_adc_res,
    output logic o_adc_ref_single,
    output logic o_adc_short_gnd,
    output logic o_thermistor_src_en
);
    import gca_pkg::*;

    logic [7:0] ctrl_q [8];
    logic [15:0] result_q [8];
    logic [7:0] sum_ctl_q;
    gca_seq_state_type state_q;
    logic [2:0] slot_q;
    logic [31:0] conv_cnt_q;
    logic half_tick;
    logic [7:0] cnt_en;
    logic [31:0] cnt_add [8];
    logic [31:0] cnt_val [8];
    logic [7:0] cur_ctrl;
    logic [2:0] cur_res;
    logic [2:0] cur_sel;
    logic [3:0] cur_bits;
    logic [31:0] conv_len;
    logic conv_last;
    logic [2:0] route_sel;
    logic [7:0] res_off;
    logic [7:0] cnt_off;
    logic [15:0] res_word;
    logic [31:0] cnt_word;
    logic cur_sign;
    logic [14:0] cur_mag;
    logic cur_flow;
    logic [15:0] therm_src;
    logic [14:0] therm_mag;
    logic [14:0] aux_mag;

    // keeps only the magnitude bits that a code actually resolves
    function automatic logic [14:0] mag_mask(input logic [2:0] res);
        mag_mask = `GCA_MAG_FULL << (3'h7 - res);
    endfunction

    // slot being looked at by the sequencer
    assign cur_ctrl = ctrl_q[slot_q];
    assign cur_res = cur_ctrl[`GCA_CTL_RES_HI:`GCA_CTL_RES_LO]; // see [RULE1]
    assign cur_sel = cur_ctrl[`GCA_CTL_SEL_HI:`GCA_CTL_SEL_LO]; // see [RULE1]
    assign cur_bits = `GCA_MIN_BITS + {1'b0, cur_res}; // see [RULE19]
    // conversion length in clocks, at most about two seconds at 15 bits
    assign conv_len = CONV_UNIT_CYCLES[31:0]
        << ({1'b0, cur_bits} + 5'h01); // see [RULE20]
    assign conv_last = (state_q == GCA_ST_CONV)
        && (conv_cnt_q == `GCA_CNT_RESET);

    // zero-cal slot always converts a grounded input (see [RULE7])
    always_comb begin
        if (slot_q == `GCA_SLOT_ZERO_CAL) begin
            route_sel = `GCA_SEL_ZERO_CAL;
        end else begin
            route_sel = cur_sel; // see [RULE3]
        end
    end

    // host writes: control slots and the sum control byte
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            for (int i = 0; i < 8; i++) begin
                ctrl_q[i] <= `GCA_CTL_RESET;
            end
            sum_ctl_q <= `GCA_SUM_RESET;
        // results and counters are read-only; writes to them are dropped
        end else if (i_reg_wr_en) begin
            if (i_reg_addr <= `GCA_ADDR_CTRL_LAST) begin
                ctrl_q[i_reg_addr[2:0]] <= i_reg_wdata; // see [RULE1]
            end else if (i_reg_addr == `GCA_ADDR_SUM_CTL) begin
                sum_ctl_q <= i_reg_wdata;
            end
        end
    end

    // sequencer: one slot per pass, a disabled slot costs one clock
    // a control write mid-conversion only takes effect on the next pass
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            state_q <= GCA_ST_SCAN;
            slot_q <= `GCA_SLOT_CURRENT;
            conv_cnt_q <= `GCA_CNT_RESET;
            o_adc_active <= 1'b0;
            o_adc_input_sel <= `GCA_SEL_SENSE;
            o_adc_res <= 3'h0;
            o_adc_ref_single <= 1'b0;
            o_adc_short_gnd <= 1'b0;
            o_thermistor_src_en <= 1'b0;
        end else begin
            case (state_q)
                GCA_ST_SCAN: begin
                    // reserved slot never converts, even if enabled
                    if (cur_ctrl[`GCA_CTL_EN]
                        && (slot_q != `GCA_SLOT_RESERVED)) begin // see [RULE18]
                        state_q <= GCA_ST_CONV;
                        conv_cnt_q <= conv_len - 32'h0000_0001; // see [RULE20]
                        o_adc_active <= 1'b1;
                        o_adc_input_sel <= route_sel;
                        o_adc_res <= cur_res;
                        o_adc_ref_single <= cur_ctrl[`GCA_CTL_REF];
                        // input tied to ground for offset measurement
                        o_adc_short_gnd <=
                            (route_sel == `GCA_SEL_ZERO_CAL); // see [RULE7]
                        // source only powered while it is being measured
                        o_thermistor_src_en <=
                            (route_sel == `GCA_SEL_EXT_TEMP); // see [RULE6]
                    end else begin
                        slot_q <= slot_q + 3'h1; // see [RULE18]
                    end
                end
                GCA_ST_CONV: begin
                    if (conv_last) begin
                        state_q <= GCA_ST_SCAN;
                        slot_q <= slot_q + 3'h1; // see [RULE18]
                        o_adc_active <= 1'b0;
                        o_adc_short_gnd <= 1'b0;
                        o_thermistor_src_en <= 1'b0; // see [RULE6]
                    end else begin
                        conv_cnt_q <= conv_cnt_q - 32'h0000_0001;
                    end
                end
                default: begin
                    state_q <= GCA_ST_SCAN;
                    o_adc_active <= 1'b0;
                    o_adc_short_gnd <= 1'b0;
                    o_thermistor_src_en <= 1'b0;
                end
            endcase
        end
    end

    // result capture at the end of a conversion, padded with zeros
    // slot_q still names the running slot here; it steps on this same edge
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            for (int i = 0; i < 8; i++) begin
                result_q[i] <= `GCA_RES_RESET;
            end
        end else if (conv_last) begin
            result_q[slot_q] <= {i_adc_result[`GCA_RES_SIGN],
                i_adc_result[14:0] & mag_mask(o_adc_res)}; // see [RULE17]
        end
    end

    // half-second update strobe
    // one pulse feeds every counter, so all counters that update do so in the same cycle
    gca_half_sec_tick #(
        .CYCLES(HALF_SEC_CYCLES)
    ) u_tick (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .o_tick(half_tick)
    );

    // current channel split by sign; only the current slot feeds it
    assign cur_sign = result_q[`GCA_SLOT_CURRENT][`GCA_RES_SIGN]; // see [RULE4]
    assign cur_mag =
        result_q[`GCA_SLOT_CURRENT][`GCA_MAG_HI:0]; // see [RULE17]
    // zero magnitude counts as no flow, so neither timer runs
    assign cur_flow = |cur_mag;

    // thermal source chosen by software between the two sensors
    always_comb begin
        if (sum_ctl_q[`GCA_SUM_THERM_EXT]) begin
            therm_src = result_q[`GCA_SLOT_EXT_TEMP]; // see [RULE9]
        end else begin
            therm_src = result_q[`GCA_SLOT_INT_TEMP]; // see [RULE9]
        end
    end

    // sums take the magnitude only; the sign just steers current
    assign therm_mag = therm_src[`GCA_MAG_HI:0]; // see [RULE9]
    assign aux_mag = result_q[`GCA_SLOT_AUX][`GCA_MAG_HI:0]; // see [RULE9]

    // update requests and addends for the eight counters
    always_comb begin
        cnt_en = 8'h00;
        cnt_en[`GCA_CNT_DRAIN] = half_tick
            && sum_ctl_q[`GCA_SUM_ACCUM] && cur_sign; // see [RULE12] [RULE14]
        cnt_en[`GCA_CNT_CHARGE] = half_tick
            && sum_ctl_q[`GCA_SUM_ACCUM] && !cur_sign; // see [RULE11] [RULE14]
        cnt_en[`GCA_CNT_THERMAL] = half_tick
            && sum_ctl_q[`GCA_SUM_THERM_EN]; // see [RULE10]
        cnt_en[`GCA_CNT_AUX] = half_tick
            && sum_ctl_q[`GCA_SUM_AUX_EN]; // see [RULE10]
        // one step per half second gives two counts per second
        cnt_en[`GCA_CNT_DIS_TIMER] = half_tick && sum_ctl_q[`GCA_SUM_TIMER_EN]
            && cur_sign && cur_flow; // see [RULE16] [RULE4]
        cnt_en[`GCA_CNT_CHG_TIMER] = half_tick && sum_ctl_q[`GCA_SUM_TIMER_EN]
            && !cur_sign && cur_flow; // see [RULE15] [RULE4]
        // thermal and aux timers count half-seconds while their sum runs
        cnt_en[`GCA_CNT_THERM_TIMER] = half_tick
            && sum_ctl_q[`GCA_SUM_THERM_EN];
        cnt_en[`GCA_CNT_AUX_TIMER] = half_tick && sum_ctl_q[`GCA_SUM_AUX_EN];
        // magnitudes already carry the conversion resolution (see [RULE13])
        cnt_add[`GCA_CNT_DRAIN] = {17'h00000, cur_mag}; // see [RULE12]
        cnt_add[`GCA_CNT_CHARGE] = {17'h00000, cur_mag}; // see [RULE11]
        cnt_add[`GCA_CNT_THERMAL] = {17'h00000, therm_mag}; // see [RULE9]
        cnt_add[`GCA_CNT_AUX] = {17'h00000, aux_mag}; // see [RULE9]
        cnt_add[`GCA_CNT_DIS_TIMER] = `GCA_TIMER_STEP;
        cnt_add[`GCA_CNT_CHG_TIMER] = `GCA_TIMER_STEP;
        cnt_add[`GCA_CNT_THERM_TIMER] = `GCA_TIMER_STEP;
        cnt_add[`GCA_CNT_AUX_TIMER] = `GCA_TIMER_STEP;
    end

    // four accumulators then four time counters (see [RULE8])
    for (genvar g = 0; g < 8; g++) begin : g_cnt
        gca_accum_cell u_cell (
            .i_clock(i_clock),
            .i_sys_rst(i_sys_rst),
            .i_add_en(cnt_en[g]),
            .i_addend(cnt_add[g]),
            .o_value(cnt_val[g])
        );
    end

    // read window offsets
    assign res_off = i_reg_addr - `GCA_ADDR_RES_BASE;
    assign cnt_off = i_reg_addr - `GCA_ADDR_CNT_BASE;
    assign res_word = result_q[res_off[3:1]];
    assign cnt_word = cnt_val[cnt_off[4:2]];

    // registered read data, low byte at the lower address
    // multi-byte values are not latched, so a read may straddle an update
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_reg_rdata <= `GCA_READ_ZERO;
            o_reg_rd_valid <= 1'b0;
        end else begin
            o_reg_rd_valid <= i_reg_rd_en;
            if (!i_reg_rd_en) begin
                o_reg_rdata <= o_reg_rdata;
            end else if (i_reg_addr <= `GCA_ADDR_CTRL_LAST) begin
                o_reg_rdata <= ctrl_q[i_reg_addr[2:0]];
            end else if (i_reg_addr <= `GCA_ADDR_RES_LAST) begin
                o_reg_rdata <= res_off[0] ? res_word[15:8] : res_word[7:0];
            end else if ((i_reg_addr >= `GCA_ADDR_CNT_BASE)
                && (i_reg_addr <= `GCA_ADDR_CNT_LAST)) begin
                case (cnt_off[1:0])
                    2'h0: o_reg_rdata <= cnt_word[7:0];
                    2'h1: o_reg_rdata <= cnt_word[15:8];
                    2'h2: o_reg_rdata <= cnt_word[23:16];
                    default: o_reg_rdata <= cnt_word[31:24];
                endcase
            end else if (i_reg_addr == `GCA_ADDR_SUM_CTL) begin
                o_reg_rdata <= sum_ctl_q;
            // status: converter busy flag and the slot being looked at
            end else if (i_reg_addr == `GCA_ADDR_STATUS) begin
                o_reg_rdata <= {4'h0, o_adc_active, slot_q};
            end else begin
                o_reg_rdata <= `GCA_READ_ZERO;
            end
        end
    end
endmodule

// File: testbench/gca_adc_model.sv
// behavioural analog converter answering on the selected input
`timescale 1ns/100ps
module gca_adc_model (
    // clock
    input wire logic i_clock,
    // converter control from the block
    input wire logic i_active,
    input wire logic [2:0] i_sel,
    // sense value set by the bench
    input wire logic [15:0] i_sense,
    // sign-magnitude result
    output logic [15:0] o_result
);
    initial o_result = 16'h5a5a;

    // idle line toggles so a stray sample never looks valid
    always @(posedge i_clock) begin
        if (!i_active) begin
            o_result <= ~o_result;
        end else begin
            case (i_sel)
                3'h0: o_result <= i_sense;
                3'h1: o_result <= 16'h2a00;
                3'h2: o_result <= 16'h5100;
                3'h3: o_result <= 16'h1333;
                3'h5: o_result <= 16'h0c80;
                3'h6: o_result <= 16'h0280;
                default: o_result <= 16'h7fff;
            endcase
        end
    end
endmodule

// File: testbench/gca_top_checker.sv
// port-level assertions for the gauge channel block
`timescale 1ns/100ps
module gca_top_checker #(
    parameter int unsigned CONV_UNIT_CYCLES = 1,
    parameter int unsigned HALF_SEC_CYCLES = 64
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // register port
    input wire logic i_reg_wr_en,
    input wire logic i_reg_rd_en,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rd_valid,
    // converter side
    input wire logic [15:0] i_adc_result,
    input wire logic o_adc_active,
    input wire logic [2:0] o_adc_input_sel,
    input wire logic [2:0] o_adc_res,
    input wire logic o_adc_ref_single,
    input wire logic o_adc_short_gnd,
    input wire logic o_thermistor_src_en
);
    logic [31:0] act_cnt_q;

    // length of the running conversion, cleared between conversions
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || !o_adc_active) begin
            act_cnt_q <= 32'h0000_0000;
        end else begin
            act_cnt_q <= act_cnt_q + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    rd_valid_pulse_a: assert property (i_reg_rd_en |=> o_reg_rd_valid)
        else $error("read strobe got no valid");
    unmapped_read_a: assert property (i_reg_rd_en && (i_reg_addr inside
        {[8'h18:8'h1f], [8'h42:8'hff]}) |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    status_read_a: assert property (i_reg_rd_en && i_reg_addr == 8'h41 |=>
        o_reg_rdata[7:3] == {4'h0, $past(o_adc_active)})
        else $error("status byte wrong");
    therm_source_a: assert property (o_thermistor_src_en ==
        (o_adc_active && o_adc_input_sel == 3'h2))
        else $error("thermistor source out of conversion");
    zero_short_a: assert property (o_adc_short_gnd ==
        (o_adc_active && o_adc_input_sel == 3'h6))
        else $error("input short wrong");
    adc_setup_a: assert property (
        o_adc_active && $past(o_adc_active) |->
        $stable(o_adc_input_sel) && $stable(o_adc_res)
        && $stable(o_adc_ref_single))
        else $error("converter setup moved in conversion");
    conv_length_a: assert property ($fell(o_adc_active) |->
        act_cnt_q == (CONV_UNIT_CYCLES << (32'(o_adc_res) + 32'h9)))
        else $error("conversion length wrong");
    reset_quiet_a: assert property (disable iff (1'b0) i_sys_rst |=>
        !o_adc_active && !o_reg_rd_valid && o_adc_input_sel == 3'h0)
        else $error("outputs active after reset");

    // main scenarios reached
    cover property ($fell(o_adc_active));
    cover property (o_thermistor_src_en);
    cover property (o_adc_short_gnd);
    cover property (o_reg_rd_valid && o_reg_rdata != 8'h00);
endmodule

bind gca_top gca_top_checker #(.CONV_UNIT_CYCLES(CONV_UNIT_CYCLES),
    .HALF_SEC_CYCLES(HALF_SEC_CYCLES)) gca_top_checker_inst (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_reg_wr_en(i_reg_wr_en),
    .i_reg_rd_en(i_reg_rd_en), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_rd_valid(o_reg_rd_valid), .i_adc_result(i_adc_result),
    .o_adc_active(o_adc_active), .o_adc_input_sel(o_adc_input_sel),
    .o_adc_res(o_adc_res), .o_adc_ref_single(o_adc_ref_single),
    .o_adc_short_gnd(o_adc_short_gnd),
    .o_thermistor_src_en(o_thermistor_src_en));

// File: testbench/test_gauge_channel_accumulation.sv
// self-checking bench for the gauge channel block
`timescale 1ns/100ps
module test_gauge_channel_accumulation;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_reg_wr_en = 1'b0;
    logic i_reg_rd_en = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic [15:0] sense_val = 16'h0123;
    logic [15:0] adc_result;
    logic [7:0] o_reg_rdata;
    logic o_reg_rd_valid, o_adc_active, o_adc_ref_single;
    logic o_adc_short_gnd, o_thermistor_src_en;
    logic [2:0] o_adc_input_sel, o_adc_res;
    logic [31:0] chg_acc, chg_tmr, v0, v1, v2, v3;
    logic [7:0] b0, b1;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #5 i_clock = ~i_clock;

    gca_top #(.CONV_UNIT_CYCLES(1), .HALF_SEC_CYCLES(64)) gca_top_inst (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_reg_wr_en(i_reg_wr_en),
        .i_reg_rd_en(i_reg_rd_en), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .o_reg_rd_valid(o_reg_rd_valid), .i_adc_result(adc_result),
        .o_adc_active(o_adc_active), .o_adc_input_sel(o_adc_input_sel),
        .o_adc_res(o_adc_res), .o_adc_ref_single(o_adc_ref_single),
        .o_adc_short_gnd(o_adc_short_gnd),
        .o_thermistor_src_en(o_thermistor_src_en));

    gca_adc_model gca_adc_model_inst (.i_clock(i_clock),
        .i_active(o_adc_active), .i_sel(o_adc_input_sel),
        .i_sense(sense_val), .o_result(adc_result));

    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clock);
        i_reg_wr_en = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(negedge i_clock);
        i_reg_wr_en = 1'b0;
    endtask

    // data arrives one cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clock);
        i_reg_rd_en = 1'b1;
        i_reg_addr = a;
        @(negedge i_clock);
        i_reg_rd_en = 1'b0;
        d = o_reg_rdata;
        check("rd_valid", o_reg_rd_valid, 1'b1);
    endtask

    // counters are little-endian, four bytes
    task automatic rd32(input logic [7:0] a, output logic [31:0] v);
        logic [7:0] b;
        for (int i = 0; i < 4; i++) begin
            rd(a + 8'(i), b);
            v[8*i +: 8] = b;
        end
    endtask

    // park until the sequencer is converting the given input
    task automatic wait_conv(input logic [2:0] sel);
        for (int k = 0; k < 6000; k++) begin
            if (o_adc_active && o_adc_input_sel == sel) break;
            @(negedge i_clock);
        end
    endtask

    // run the sums for five ticks, then freeze them for reading
    task automatic sum_window(input logic [7:0] bits);
        wr(8'h40, bits);
        repeat (320) @(negedge i_clock);
        wr(8'h40, 8'h00);
        repeat (4) @(negedge i_clock);
    endtask

    task automatic test_regs;
        rd(8'h40, b0);
        check("sum_ctl_reset", b0, 8'h00);
        rd(8'h00, b0);
        check("ctrl_reset", b0, 8'h00);
        wr(8'h07, 8'h3c);
        rd(8'h07, b0);
        check("ctrl_rw", b0, 8'h3c);
        wr(8'h08, 8'hff);
        rd(8'h08, b0);
        check("result_ro", b0, 8'h00);
        rd(8'h50, b0);
        check("unmapped", b0, 8'h00);
        rd(8'h41, b0);
        check("status_idle", b0[7:3], 5'h00);
    endtask

    task automatic test_charge;
        wr(8'h00, 8'h80);
        wait_conv(3'h0);
        check("cur_setup", {o_adc_res, o_adc_ref_single, o_adc_input_sel},
            7'h00);
        repeat (1200) @(negedge i_clock);
        rd(8'h08, b0);
        rd(8'h09, b1);
        check("cur_result", {b1, b0}, 16'h0100);
        rd32(8'h24, v0);
        check("chg_idle", v0, 32'h0);
        sum_window(8'h11);
        rd32(8'h24, chg_acc);
        rd32(8'h34, chg_tmr);
        rd32(8'h20, v2);
        rd32(8'h30, v3);
        check("chg_acc", chg_acc, chg_tmr * 32'h100);
        check("chg_tmr_run", chg_tmr == 32'h0, 1'b0);
        check("drain_acc", v2, 32'h0);
        check("dis_tmr", v3, 32'h0);
    endtask

    task automatic test_discharge;
        sense_val = 16'h8a05;
        repeat (1200) @(negedge i_clock);
        rd(8'h08, b0);
        rd(8'h09, b1);
        check("dis_result", {b1, b0}, 16'h8a00);
        sum_window(8'h11);
        rd32(8'h20, v0);
        rd32(8'h30, v1);
        rd32(8'h24, v2);
        rd32(8'h34, v3);
        check("drain_acc", v0, v1 * 32'ha00);
        check("dis_tmr_run", v1 == 32'h0, 1'b0);
        check("chg_hold", v2, chg_acc);
        check("chg_tmr_hold", v3, chg_tmr);
    endtask

    task automatic test_channels;
        wr(8'h00, 8'h00);
        wr(8'h01, 8'h89);
        wr(8'h02, 8'h8a);
        wr(8'h03, 8'hab);
        wr(8'h05, 8'h8d);
        wr(8'h06, 8'h86);
        wait_conv(3'h2);
        check("ext_setup", {o_thermistor_src_en, o_adc_short_gnd,
            o_adc_ref_single}, 3'h5);
        wait_conv(3'h3);
        check("pack_setup", {o_thermistor_src_en, o_adc_res,
            o_adc_ref_single}, 5'h05);
        wait_conv(3'h6);
        check("zero_setup", {o_adc_short_gnd, o_thermistor_src_en},
            2'h2);
        repeat (1000) @(negedge i_clock);
        rd(8'h14, b0);
        rd(8'h15, b1);
        check("zero_cal", {b1, b0}, 16'h0280);
        rd(8'h0e, b0);
        rd(8'h0f, b1);
        check("pack_res", {b1, b0}, 16'h1320);
        sum_window(8'h0e);
        rd32(8'h28, v0);
        rd32(8'h38, v1);
        rd32(8'h2c, v2);
        rd32(8'h3c, v3);
        check("thermal", v0, v1 * 32'h5100);
        check("therm_run", v1 == 32'h0, 1'b0);
        check("aux_acc", v2, v3 * 32'h0c80);
        check("aux_run", v3 == 32'h0, 1'b0);
    endtask

    task automatic wrap_up;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // hang guard, several times the expected run
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        repeat (8) @(negedge i_clock);
        i_sys_rst = 1'b0;
        test_regs();
        test_charge();
        test_discharge();
        test_channels();
        wrap_up();
    end
endmodule
